// ==== hdl/dbawf_pkg.sv ====
// Behaviour
// RL1 - Two independent differential channels each yield their own result word, tagged by channel.
// RL2 - The 12 significant bits sit left-aligned in the 16-bit word and the low bits carry no meaning.
// RL3 - Standard format is two's complement: +10 V near 7ff0, 0 V is zero, -10 V is 8000.
// RL4 - Standard format above positive full scale gives word 7fff and status code 42; the code writes status 2a, which is 42 decimal.
// RL5 - Standard format below negative full scale gives word 8000 and status code 41; the code writes status 29, which is 41 decimal.
// RL6 - Alternate format carries three status flags in bits 0 to 2 of each data word.
// RL7 - Alternate format carries the converted value in bits 3 to 15 above the flags.
// RL8 - Of the flags, bit 2 has no meaning, bit 1 flags a short or open input, bit 0 flags overflow.
// RL9 - Alternate format uses offset coding: 0 V is 4000, +10 V is 7ff8, lower voltages go toward zero.
// RL10 - Alternate format gives 7ff9 above full scale and 0001, overflow flag alone, below it.
// RL11 - Each channel word is 16 data bits travelling with an 8-bit control/status byte.
// RL12 - Standard format reports range codes in the status byte, zero while in range.
package dbawf_pkg;
  localparam int CHAN_COUNT = 2;
  localparam int CODE_W = 12;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int PAYLOAD_W = 1 + STAT_W + DATA_W;
  // Standard format
  localparam logic [15:0] STD_POS_SAT = 16'h7fff;
  localparam logic [15:0] STD_NEG_SAT = 16'h8000;
  localparam logic [3:0] STD_LOW_FILL = 4'h0;
  localparam logic [7:0] STAT_IN_RANGE = 8'h00;
  localparam logic [7:0] STAT_OVER = 8'h2a;
  localparam logic [7:0] STAT_UNDER = 8'h29;
  // Alternate format
  localparam logic [15:0] ALT_POS_OVR = 16'h7ff9;
  localparam logic [15:0] ALT_NEG_OVR = 16'h0001;
  localparam int FLAG_OVR_POS = 0;
  localparam int FLAG_ERR_POS = 1;
  localparam int FLAG_NONE_POS = 2;
  localparam int ALT_VAL_LSB = 3;
endpackage

// ==== hdl/dbawf_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Valid/ready word stream into the formatter's queue and from it to the output stage
interface dbawf_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hdl/dbawf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbawf_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Streams
  dbawf_stream_if.snk inIf,
  dbawf_stream_if.src outIf
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [CW-1:0] count_reg, count_next;
  logic doPush, doPop;

  // Honest flags straight from the occupancy count
  assign inIf.ready = (count_reg != FULL_CNT);
  assign outIf.valid = (count_reg != '0);
  assign outIf.data = mem_reg[rdPtr_reg];

  // Pointer and storage update; push and pop may share a cycle
  always_comb begin
    mem_next = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    doPush = inIf.valid && inIf.ready;
    doPop = outIf.valid && outIf.ready;
    if (doPush) begin
      mem_next[wrPtr_reg] = inIf.data;
      wrPtr_next = (wrPtr_reg == LAST_IDX) ? '0 : wrPtr_reg + AW'(1);
    end
    if (doPop) begin
      rdPtr_next = (rdPtr_reg == LAST_IDX) ? '0 : rdPtr_reg + AW'(1);
    end
    if (doPush && !doPop) begin
      count_next = count_reg + CW'(1);
    end else if (doPop && !doPush) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      mem_reg <= mem_next;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst) count_reg <= FULL_CNT) // see RL11
    else $error("queue count beyond depth");
  fifo_full_a: assert property (@(posedge clk) disable iff (rst) // see RL11
    (count_reg == FULL_CNT && !outIf.ready) |=> (count_reg == FULL_CNT && !inIf.ready))
    else $error("full queue lost its fill");
  fifo_fill_c: cover property (@(posedge clk) disable iff (rst) count_reg == FULL_CNT);
endmodule
`default_nettype wire

// ==== hdl/dbawf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbawf_top #(
  parameter int DEPTH = dbawf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Format select: high picks embedded-flag offset coding
  input wire logic altFormat,
  // Conversion results from the converter sequencer
  input wire logic smpValid,
  input wire logic smpChan,
  input wire logic [dbawf_pkg::CODE_W-1:0] smpCode,
  input wire logic smpOver,
  input wire logic smpUnder,
  input wire logic smpFault,
  output logic smpReady,
  // Formatted channel words toward the bus coupler side
  output logic outValid,
  input wire logic outReady,
  output logic outChan,
  output logic [dbawf_pkg::DATA_W-1:0] outData,
  output logic [dbawf_pkg::STAT_W-1:0] outStatus
);
  localparam int CW = dbawf_pkg::CODE_W;

  // Builds {status, data} for one result; overrange beats underrange
  function automatic logic [23:0] fmtWord(input logic [CW-1:0] code, input logic over,
                                          input logic under, input logic fault, input logic alt);
    logic [15:0] word;
    logic [7:0] stat;
    word = {code, dbawf_pkg::STD_LOW_FILL}; // see RL2 see RL3
    stat = dbawf_pkg::STAT_IN_RANGE; // see RL12
    if (alt) begin
      word = {1'b0, ~code[CW-1], code[CW-2:0], 3'b000}; // see RL7 see RL9
      if (over) begin
        word = dbawf_pkg::ALT_POS_OVR; // see RL10
      end else if (under) begin
        word = dbawf_pkg::ALT_NEG_OVR; // see RL10
      end
      word[dbawf_pkg::FLAG_NONE_POS] = 1'b0; // see RL6 see RL8
      if (!under) begin
        word[dbawf_pkg::FLAG_ERR_POS] = fault; // see RL8
      end
    end else if (over) begin
      word = dbawf_pkg::STD_POS_SAT; // see RL4
      stat = dbawf_pkg::STAT_OVER; // see RL4 see RL12
    end else if (under) begin
      word = dbawf_pkg::STD_NEG_SAT; // see RL5
      stat = dbawf_pkg::STAT_UNDER; // see RL5 see RL12
    end
    return {stat, word};
  endfunction

  logic fmtValid_reg, fmtValid_next;
  logic fmtChan_reg, fmtChan_next;
  logic [15:0] fmtData_reg, fmtData_next;
  logic [7:0] fmtStatus_reg, fmtStatus_next;
  logic smpReady_reg, smpReady_next;
  logic outValid_reg, outValid_next;
  logic outChan_reg, outChan_next;
  logic [15:0] outData_reg, outData_next;
  logic [7:0] outStatus_reg, outStatus_next;
  logic [23:0] fmtPacked;

  dbawf_stream_if #(.W(dbawf_pkg::PAYLOAD_W)) fifoIn ();
  dbawf_stream_if #(.W(dbawf_pkg::PAYLOAD_W)) fifoOut ();

  // Four-word queue absorbs stalls from the coupler side
  dbawf_fifo #(
    .WIDTH(dbawf_pkg::PAYLOAD_W),
    .DEPTH(DEPTH)
  ) uQueue (
    .clk(ref_clk),
    .rst(sys_rst),
    .inIf(fifoIn.snk),
    .outIf(fifoOut.src)
  );

  // Channel tag travels with each word so both channels stay apart
  assign fifoIn.valid = fmtValid_reg;
  assign fifoIn.data = {fmtChan_reg, fmtStatus_reg, fmtData_reg}; // see RL1 see RL11
  assign fifoOut.ready = !outValid_reg || outReady;
  assign fmtPacked = fmtWord(smpCode, smpOver, smpUnder, smpFault, altFormat);

  // Format stage; one result held at a time, a full queue stalls the source
  always_comb begin
    fmtValid_next = fmtValid_reg;
    fmtChan_next = fmtChan_reg;
    fmtData_next = fmtData_reg;
    fmtStatus_next = fmtStatus_reg;
    if (fmtValid_reg && fifoIn.ready) begin
      fmtValid_next = 1'b0;
    end
    if (smpValid && smpReady_reg) begin
      fmtValid_next = 1'b1;
      fmtChan_next = smpChan; // see RL1
      fmtData_next = fmtPacked[15:0];
      fmtStatus_next = fmtPacked[23:16]; // see RL11
    end
    // Registered ready costs a bubble per word, far below the conversion rate
    smpReady_next = !fmtValid_next;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fmtValid_reg <= 1'b0;
      fmtChan_reg <= 1'b0;
      fmtData_reg <= 16'h0000;
      fmtStatus_reg <= 8'h00;
      smpReady_reg <= 1'b0;
    end else begin
      fmtValid_reg <= fmtValid_next;
      fmtChan_reg <= fmtChan_next;
      fmtData_reg <= fmtData_next;
      fmtStatus_reg <= fmtStatus_next;
      smpReady_reg <= smpReady_next;
    end
  end

  // Output stage keeps every port on a flop
  always_comb begin
    outValid_next = outValid_reg;
    outChan_next = outChan_reg;
    outData_next = outData_reg;
    outStatus_next = outStatus_reg;
    if (fifoOut.ready) begin
      outValid_next = fifoOut.valid;
      if (fifoOut.valid) begin
        outChan_next = fifoOut.data[24];
        outStatus_next = fifoOut.data[23:16];
        outData_next = fifoOut.data[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid_reg <= 1'b0;
      outChan_reg <= 1'b0;
      outData_reg <= 16'h0000;
      outStatus_reg <= 8'h00;
    end else begin
      outValid_reg <= outValid_next;
      outChan_reg <= outChan_next;
      outData_reg <= outData_next;
      outStatus_reg <= outStatus_next;
    end
  end

  assign smpReady = smpReady_reg;
  assign outValid = outValid_reg;
  assign outChan = outChan_reg;
  assign outData = outData_reg;
  assign outStatus = outStatus_reg;

  // Assertion helper: results taken at the input but not yet taken at the output
  localparam int FW = $clog2(DEPTH + 3);
  localparam logic [FW-1:0] FLIGHT_MAX = FW'(DEPTH + 2);
  logic [FW-1:0] inFlight_reg, inFlight_next;
  logic takeIn, takeOut;

  // One up per input handshake, one down per output handshake
  always_comb begin
    takeIn = smpValid && smpReady_reg;
    takeOut = outValid_reg && outReady;
    inFlight_next = inFlight_reg;
    if (takeIn && !takeOut) begin
      inFlight_next = inFlight_reg + FW'(1);
    end else if (takeOut && !takeIn) begin
      inFlight_next = inFlight_reg - FW'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inFlight_reg <= '0;
    end else begin
      inFlight_reg <= inFlight_next;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence takeStd;
    smpValid && smpReady_reg && !altFormat;
  endsequence
  sequence takeAlt;
    smpValid && smpReady_reg && altFormat;
  endsequence

  std_over_a: assert property (takeStd and smpOver |=> // see RL4
    fmtData_reg == dbawf_pkg::STD_POS_SAT && fmtStatus_reg == dbawf_pkg::STAT_OVER)
    else $error("standard overrange word or code wrong");
  std_under_a: assert property (takeStd and (!smpOver && smpUnder) |=> // see RL5
    fmtData_reg == dbawf_pkg::STD_NEG_SAT && fmtStatus_reg == dbawf_pkg::STAT_UNDER)
    else $error("standard underrange word or code wrong");
  std_range_a: assert property (takeStd and (!smpOver && !smpUnder) |=> // see RL3
    fmtData_reg[15:4] == $past(smpCode) && fmtData_reg[3:0] == 4'h0
    && fmtStatus_reg == dbawf_pkg::STAT_IN_RANGE)
    else $error("standard in-range word wrong");
  alt_value_a: assert property (takeAlt and (!smpOver && !smpUnder) |=> // see RL9
    fmtData_reg[15:3] == {1'b0, ~$past(smpCode[11]), $past(smpCode[10:0])})
    else $error("offset coded value wrong");
  alt_flags_a: assert property (takeAlt and !smpUnder |=> // see RL8
    fmtData_reg[2] == 1'b0 && fmtData_reg[1] == $past(smpFault)
    && fmtData_reg[0] == $past(smpOver))
    else $error("embedded flags wrong");
  alt_under_a: assert property (takeAlt and (!smpOver && smpUnder) |=> // see RL10
    fmtData_reg == dbawf_pkg::ALT_NEG_OVR && fmtStatus_reg == 8'h00)
    else $error("offset underrange word wrong");
  chan_tag_a: assert property (smpValid && smpReady_reg |=> // see RL1
    fmtValid_reg && !smpReady_reg && fmtChan_reg == $past(smpChan))
    else $error("channel tag or stall wrong");
  out_hold_a: assert property (outValid_reg && !outReady |=> // see RL11
    outValid_reg && $stable(outData_reg) && $stable(outStatus_reg) && $stable(outChan_reg))
    else $error("output word changed while stalled");
  pass_time_a: assert property (fmtValid_reg && fifoIn.ready && !outValid_reg && fifoOut.valid == 1'b0 // see RL11
    |=> ##1 outValid_reg)
    else $error("word did not reach output in two cycles");
  pass_word_a: assert property (fmtValid_reg && fifoIn.ready && !outValid_reg && !fifoOut.valid |=> ##1 // see RL11
    outChan_reg == $past(fmtChan_reg, 2) && outStatus_reg == $past(fmtStatus_reg, 2)
    && outData_reg == $past(fmtData_reg, 2))
    else $error("word changed on its way to the output");
  alt_over_a: assert property (takeAlt and smpOver |=> // see RL10
    fmtData_reg[15:3] == dbawf_pkg::ALT_POS_OVR[15:3] && fmtData_reg[dbawf_pkg::FLAG_OVR_POS] == 1'b1)
    else $error("offset overrange word wrong");
  std_low_a: assert property (takeStd and !smpOver |=> fmtData_reg[3:0] == dbawf_pkg::STD_LOW_FILL) // see RL2
    else $error("standard low bits not cleared");
  alt_status_a: assert property (takeAlt |=> fmtStatus_reg == dbawf_pkg::STAT_IN_RANGE) // see RL6
    else $error("status byte used in offset format");

  // Occupancy of the whole path; a lost or invented word breaks these
  flight_bound_a: assert property (inFlight_reg <= FLIGHT_MAX) // see RL1
    else $error("more results in flight than the path holds");
  flight_full_a: assert property (inFlight_reg == FLIGHT_MAX |-> !smpReady_reg) // see RL11
    else $error("input accepted with the path full");
  flight_idle_a: assert property (inFlight_reg == '0 |-> !outValid_reg && !fmtValid_reg) // see RL1
    else $error("word shown with none taken");
  flight_show_a: assert property (inFlight_reg != '0 |-> ##[0:2] outValid_reg) // see RL11
    else $error("taken word not shown at the output");

  std_over_c: cover property (takeStd and smpOver);
  alt_under_c: cover property (takeAlt and smpUnder);
  stall_c: cover property (outValid_reg && !outReady [*3]);
  both_chan_c: cover property (outValid_reg && outReady && !outChan_reg ##[1:20] outValid_reg && outChan_reg);
endmodule
`default_nettype wire

// ==== tb/dbawf_coupler_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbawf_coupler_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pacing from the bench, high holds words back
  input wire logic stall,
  // Channel words from the module
  input wire logic outValid,
  output logic outReady,
  input wire logic outChan,
  input wire logic [dbawf_pkg::DATA_W-1:0] outData,
  input wire logic [dbawf_pkg::STAT_W-1:0] outStatus
);
  // Received tag, status byte and data word, oldest first
  logic [24:0] rxQ[$];
  logic [24:0] lastWord;
  logic lastWait;
  int holdErrs = 0;

  // Takes a word only on an edge with both valid and ready high
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outReady <= 1'b0;
      lastWait <= 1'b0;
      rxQ.delete();
    end else begin
      if (outValid && outReady) begin
        rxQ.push_back({outChan, outStatus, outData});
      end
      // A waiting word may neither vanish nor change
      if (lastWait && (!outValid || {outChan, outStatus, outData} !== lastWord)) begin
        holdErrs++;
      end
      lastWait <= outValid && !outReady;
      lastWord <= {outChan, outStatus, outData};
      outReady <= !stall;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dbawf_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbawf_top_test;
  // Control bits are chan, alt, over, under, fault from the top down
  typedef struct packed {
    logic [4:0] ctl;
    logic [11:0] code;
    logic [15:0] data;
    logic [7:0] stat;
  } dbawf_row_t;
  localparam int ROWS = 14;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic altFormat = 1'b0;
  logic smpValid = 1'b0;
  logic smpChan = 1'b0;
  logic [11:0] smpCode = 12'h000;
  logic smpOver = 1'b0;
  logic smpUnder = 1'b0;
  logic smpFault = 1'b0;
  logic stall = 1'b0;
  logic smpReady, outValid, outReady, outChan;
  logic [15:0] outData;
  logic [7:0] outStatus;
  int failures = 0;
  int totalChecks = 0;
  dbawf_row_t rows [ROWS];

  dbawf_top i_dbawf_top (.ref_clk, .sys_rst, .altFormat, .smpValid, .smpChan, .smpCode, .smpOver,
    .smpUnder, .smpFault, .smpReady, .outValid, .outReady, .outChan, .outData, .outStatus);
  dbawf_coupler_model i_dbawf_coupler_model (.ref_clk, .sys_rst, .stall, .outValid, .outReady,
    .outChan, .outData, .outStatus);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Inputs always move just after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic bail;
    failures++;
    wrap_up();
  endtask

  // Offer one result and hold it until an edge with ready high takes it
  task automatic send(input dbawf_row_t r);
    int n;
    n = 0;
    tick(1);
    {smpChan, altFormat, smpOver, smpUnder, smpFault} = r.ctl;
    smpCode = r.code;
    smpValid = 1'b1;
    while (smpReady !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    if (n == 50) bail();
    tick(1);
    smpValid = 1'b0;
  endtask

  // Bounded wait for the coupler model to collect cnt words
  task automatic drain(input int cnt);
    int n;
    n = 0;
    while (i_dbawf_coupler_model.rxQ.size() < cnt && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) bail();
  endtask

  task automatic expect_rows(input int first, input int last);
    logic [24:0] w;
    for (int i = first; i <= last; i++) begin
      w = i_dbawf_coupler_model.rxQ.pop_front();
      check($sformatf("word %0d", i), 32'(w),
        32'({rows[i].ctl[4], rows[i].stat, rows[i].data}));
    end
  endtask

  initial begin
    rows = '{'{5'h00, 12'h7ff, 16'h7ff0, 8'h00}, '{5'h10, 12'h000, 16'h0000, 8'h00},
      '{5'h00, 12'h800, 16'h8000, 8'h00}, '{5'h10, 12'he00, 16'he000, 8'h00},
      '{5'h04, 12'h7ff, 16'h7fff, 8'h2a}, '{5'h12, 12'h800, 16'h8000, 8'h29},
      '{5'h07, 12'h400, 16'h7fff, 8'h2a}, '{5'h18, 12'h7ff, 16'h7ff8, 8'h00},
      '{5'h08, 12'h000, 16'h4000, 8'h00}, '{5'h18, 12'he01, 16'h3008, 8'h00},
      '{5'h09, 12'h000, 16'h4002, 8'h00}, '{5'h1d, 12'h123, 16'h7ffb, 8'h00},
      '{5'h0b, 12'h800, 16'h0001, 8'h00}, '{5'h18, 12'h800, 16'h0000, 8'h00}};
    tick(3);
    sys_rst = 1'b0;
    check("outputs after reset", 32'({smpReady, outValid, outChan, outStatus, outData}), 32'h0);
    // Ordinary cases, both channels, both formats, all range conditions
    for (int i = 0; i < ROWS; i++) begin
      send(rows[i]);
    end
    drain(ROWS);
    expect_rows(0, ROWS - 1);
    $display("Format table done");
    // Consumer stalls: six results fill the path, then input is refused
    stall = 1'b1;
    for (int i = 0; i < 6; i++) begin
      send(rows[i]);
    end
    tick(10);
    check("ready with path full", 32'(smpReady), 32'h0);
    check("waiting word", 32'({outValid, outChan, outStatus, outData}), 32'({1'b1, 1'b0, 8'h00, 16'h7ff0}));
    stall = 1'b0;
    send(rows[6]);
    drain(7);
    expect_rows(0, 6);
    check("hold breaks", 32'(i_dbawf_coupler_model.holdErrs), 32'h0);
    $display("Backpressure done");
    // Reset in mid-run with a word waiting at the output
    stall = 1'b1;
    send(rows[7]);
    tick(3);
    check("valid while stalled", 32'(outValid), 32'h1);
    sys_rst = 1'b1;
    #1;
    check("outputs in reset", 32'({smpReady, outValid, outChan, outStatus, outData}), 32'h0);
    tick(2);
    sys_rst = 1'b0;
    stall = 1'b0;
    send(rows[8]);
    drain(1);
    expect_rows(8, 8);
    $display("Mid-run reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
